/* File: shared/lms_defs.svh */
// Constants for the line mode sequencer
`ifndef LMS_DEFS_SVH
`define LMS_DEFS_SVH
`define LMS_CLK_HZ 25000000
`define LMS_CTS_DELAY_MS 330
`define LMS_CTS_CYCLES ((`LMS_CLK_HZ / 1000) * `LMS_CTS_DELAY_MS)
`define LMS_IDLE_S 15
`define LMS_IDLE_CYCLES (`LMS_CLK_HZ * `LMS_IDLE_S)
`define LMS_ADDR_CTRL 32'h00
`define LMS_ADDR_JUMP 32'h04
`define LMS_ADDR_STAT 32'h08
`define LMS_CTRL_TC_BIT 0
`define LMS_CTRL_DIAL_BIT 1
`define LMS_CTRL_MASTER_BIT 2
`define LMS_CTRL_BID_BIT 3
`define LMS_CTRL_RESET 32'h00000000
`define LMS_JUMP_RESET 32'h00000000
`define LMS_CH_EOT 8'h04
`define LMS_CH_SOM 8'h02
`define LMS_CH_SEL 8'h2c
`define LMS_CH_SLASH 8'h2f
`define LMS_CH_SPACE 8'h20
`define LMS_CH_NAK 8'h15
`endif

/* File: shared/lms_pkg.sv */
// Types for the line mode sequencer
package lms_pkg;
    typedef enum logic [8:0] {
        LMS_TEXT_NONSEL = 9'h001,
        LMS_CTRL_RECV = 9'h002,
        LMS_CTRL_ADDR = 9'h004,
        LMS_ADDR_SEL = 9'h008,
        LMS_INTER_CTRL = 9'h010,
        LMS_INTER_POLL = 9'h020,
        LMS_XMIT_TEXT = 9'h040,
        LMS_POLL_ANS = 9'h080,
        LMS_RECV_TEXT = 9'h100
    } lms_mode_e;
    typedef struct packed {
        logic no_buf_gen;
        logic send_active;
        logic no_test;
        logic strobe_off;
        logic no_operate;
        logic buf_empty;
    } lms_idle_s;
    typedef struct packed {
        logic trig_a;
        logic trig_b;
        logic trig_e;
        logic trig_f;
    } lms_trig_s;
endpackage

/* File: rtl/lms_sequencer.sv */
// Line mode sequencer with AHB-Lite register slave
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "lms_defs.svh"

// Behaviour
// - Clear-to-send held low 330 ms after request-to-send rises.
// - Start-of-message in control receive enters receive mode.
// - Slash with first and second triggers set enters intermediate control receive.
// - Space there clears fourth and second triggers, sets bid, sends start-of-message.
// - After that character is sent ring bell, start motor, unlock keyboard.
// - Non-space after slash returns to control receive.
// - Uninterrupted transmit idleness for 15 s sets the timeout latch.
// - Timeout latch sets second trigger and blocks keyboard strobe.
// - Control clock gate needs select, no blanking, no phase one, timeout.
// - Selector off gives basic terminal behaviour but keeps idle timeout.
// - Data set ready without carrier for 15 s sets timeout latch.
// - Timeout latch with no carrier performs dial disconnect.
// - Individual and group jumpered addresses plus fixed all-call address.
// - All-call is slash then space, independent of jumpers.
// - Group address only when addressing; individual in addressing and polling.
// - Master, or slave with status, accepts group calls; slave without status rejects.
// - Power-up text non-selected mode accepts only end-of-transmission.
// - End-of-transmission enters control receive mode.
// - Select character enters control address mode.
// - Only matching address selects; others wait for end or start.
// - Poll with pending send enters transmit text.
// - Poll without send request answers negative and returns to control receive.
module lms_sequencer #(
    parameter int unsigned IDLE_CYCLES = `LMS_IDLE_CYCLES,
    parameter int unsigned CTS_CYCLES = `LMS_CTS_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_char_in,
    input wire logic tx_done_in,
    input wire lms_pkg::lms_idle_s idle_in,
    input wire logic rts_in,
    input wire logic dsr_in,
    input wire logic carrier_in,
    input wire logic blanking_in,
    input wire logic first_clock_phase_in,
    input wire logic operator_eot_in,
    input wire logic has_status_in,
    output logic tx_valid_out,
    output logic [7:0] tx_char_out,
    output logic cts_out,
    output logic control_clock_gate_out,
    output logic dial_disconnect_out,
    output logic keyboard_strobe_block_out,
    output logic bell_out,
    output logic motor_on_out,
    output logic keyboard_unlock_out,
    output logic [3:0] mode_trig_out,
    output logic bid_out
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic is_alpha(input logic [7:0] c);
        is_alpha = ((c >= 8'h41) && (c <= 8'h5a)) || ((c >= 8'h61) && (c <= 8'h7a));
    endfunction

    function automatic lms_pkg::lms_trig_s trig_of(input lms_pkg::lms_mode_e m);
        case (m)
            lms_pkg::LMS_TEXT_NONSEL: trig_of = 4'b1110;
            lms_pkg::LMS_CTRL_RECV: trig_of = 4'b1100;
            lms_pkg::LMS_CTRL_ADDR: trig_of = 4'b0100;
            lms_pkg::LMS_ADDR_SEL: trig_of = 4'b0101;
            lms_pkg::LMS_INTER_CTRL: trig_of = 4'b1101;
            lms_pkg::LMS_INTER_POLL: trig_of = 4'b1111;
            lms_pkg::LMS_XMIT_TEXT: trig_of = 4'b1010;
            lms_pkg::LMS_POLL_ANS: trig_of = 4'b1011;
            lms_pkg::LMS_RECV_TEXT: trig_of = 4'b0110;
            default: trig_of = 4'b1110;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] jump_q;
    logic ap_valid_q;
    logic ap_write_q;
    logic [31:0] ap_addr_q;
    lms_pkg::lms_mode_e mode_q;
    logic timeout_q;
    logic pend_q;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 32'h0;
        end else if (clk_en_in && hready_in) begin
            ap_valid_q <= hsel_in && htrans_in[1];
            ap_write_q <= hwrite_in;
            ap_addr_q <= haddr_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_q <= `LMS_CTRL_RESET;
            jump_q <= `LMS_JUMP_RESET;
        end else if (clk_en_in && ap_valid_q && ap_write_q) begin
            if (ap_addr_q[7:0] == `LMS_ADDR_CTRL) begin
                ctrl_q <= {28'h0, hwdata_in[3:0]};
            end else if (ap_addr_q[7:0] == `LMS_ADDR_JUMP) begin
                jump_q <= {16'h0, hwdata_in[15:0]};
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hrdata_out <= 32'h0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else if (clk_en_in) begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
                case (haddr_in[7:0])
                    `LMS_ADDR_CTRL: hrdata_out <= ctrl_q;
                    `LMS_ADDR_JUMP: hrdata_out <= jump_q;
                    `LMS_ADDR_STAT: hrdata_out <= {21'h0, timeout_q, pend_q, 9'(mode_q)};
                    default: hrdata_out <= 32'h0;
                endcase
            end
        end
    end

    logic tc_sel;
    logic [7:0] indiv_addr;
    logic [7:0] group_addr;
    assign tc_sel = ctrl_q[`LMS_CTRL_TC_BIT];
    assign indiv_addr = jump_q[7:0];
    assign group_addr = jump_q[15:8];

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    logic idle_cond;
    logic nocar_cond;
    logic [31:0] idle_cnt_q;
    logic [31:0] nocar_cnt_q;
    assign idle_cond = &idle_in;
    assign nocar_cond = dsr_in && !carrier_in;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            idle_cnt_q <= 32'h0;
            nocar_cnt_q <= 32'h0;
        end else if (clk_en_in) begin
            idle_cnt_q <= (idle_cond && idle_cnt_q < IDLE_CYCLES) ? idle_cnt_q + 32'h1 :
                          (idle_cond ? idle_cnt_q : 32'h0);
            nocar_cnt_q <= (nocar_cond && nocar_cnt_q < IDLE_CYCLES) ? nocar_cnt_q + 32'h1 :
                           (nocar_cond ? nocar_cnt_q : 32'h0);
        end
    end

    // timeout latch, kept with selector off
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            timeout_q <= 1'b0;
        end else if (clk_en_in) begin
            if ((idle_cond && idle_cnt_q == IDLE_CYCLES - 1) ||
                (nocar_cond && nocar_cnt_q == IDLE_CYCLES - 1)) begin
                timeout_q <= 1'b1;
            end else if (mode_q == lms_pkg::LMS_CTRL_RECV) begin
                timeout_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Clear-to-send delay
    // ------------------------------------------------------------
    logic [31:0] cts_cnt_q;
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cts_cnt_q <= 32'h0;
            cts_out <= 1'b0;
        end else if (clk_en_in) begin
            if (!rts_in) begin
                cts_cnt_q <= 32'h0;
                cts_out <= 1'b0;
            end else if (cts_cnt_q < CTS_CYCLES - 1) begin
                cts_cnt_q <= cts_cnt_q + 32'h1;
            end else begin
                cts_out <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    logic slash_seen_q;
    logic group_hit_q;
    logic poll_ok_q;
    logic som_wait_q;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_q <= lms_pkg::LMS_TEXT_NONSEL;
            slash_seen_q <= 1'b0;
            group_hit_q <= 1'b0;
            poll_ok_q <= 1'b0;
            bid_out <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_char_out <= 8'h00;
            som_wait_q <= 1'b0;
        end else if (clk_en_in) begin
            tx_valid_out <= 1'b0;
            // Clear first so a new start-of-message wait set below wins
            if (som_wait_q && tx_done_in) som_wait_q <= 1'b0;
            if (timeout_q && mode_q == lms_pkg::LMS_XMIT_TEXT) begin
                // second trigger set returns to control receive
                mode_q <= lms_pkg::LMS_CTRL_RECV;
                bid_out <= 1'b0;
            end else if (mode_q == lms_pkg::LMS_POLL_ANS && tx_done_in) begin
                mode_q <= lms_pkg::LMS_CTRL_RECV;
            end else if (mode_q == lms_pkg::LMS_XMIT_TEXT && operator_eot_in) begin
                mode_q <= lms_pkg::LMS_CTRL_RECV;
                bid_out <= 1'b0;
            end else if (rx_valid_in) begin
                case (mode_q)
                    lms_pkg::LMS_TEXT_NONSEL: begin
                        if (rx_char_in == `LMS_CH_EOT) mode_q <= lms_pkg::LMS_CTRL_RECV;
                    end
                    lms_pkg::LMS_CTRL_RECV: begin
                        if (rx_char_in == `LMS_CH_SOM) begin
                            mode_q <= lms_pkg::LMS_RECV_TEXT;
                        end else if (rx_char_in == `LMS_CH_SEL) begin
                            mode_q <= lms_pkg::LMS_CTRL_ADDR;
                        end else if (rx_char_in == `LMS_CH_SLASH && tc_sel) begin
                            mode_q <= lms_pkg::LMS_INTER_CTRL;
                        end else if (is_alpha(rx_char_in) && rx_char_in == indiv_addr) begin
                            mode_q <= lms_pkg::LMS_INTER_POLL;
                        end
                    end
                    lms_pkg::LMS_INTER_CTRL: begin
                        if (rx_char_in == `LMS_CH_SPACE) begin
                            mode_q <= lms_pkg::LMS_XMIT_TEXT;
                            bid_out <= 1'b1;
                            tx_valid_out <= 1'b1;
                            tx_char_out <= `LMS_CH_SOM;
                            som_wait_q <= 1'b1;
                        end else begin
                            mode_q <= lms_pkg::LMS_CTRL_RECV;
                        end
                    end
                    lms_pkg::LMS_INTER_POLL: begin
                        if (rx_char_in == `LMS_CH_SPACE && pend_q) begin
                            mode_q <= lms_pkg::LMS_XMIT_TEXT;
                            bid_out <= 1'b1;
                            tx_valid_out <= 1'b1;
                            tx_char_out <= `LMS_CH_SOM;
                            som_wait_q <= 1'b1;
                        end else if (rx_char_in == `LMS_CH_SPACE) begin
                            mode_q <= lms_pkg::LMS_POLL_ANS;
                            tx_valid_out <= 1'b1;
                            tx_char_out <= `LMS_CH_NAK;
                        end else begin
                            mode_q <= lms_pkg::LMS_CTRL_RECV;
                        end
                    end
                    lms_pkg::LMS_CTRL_ADDR: begin
                        // others wait for end or start
                        if (rx_char_in == `LMS_CH_EOT) begin
                            mode_q <= lms_pkg::LMS_TEXT_NONSEL;
                            slash_seen_q <= 1'b0;
                        end else if (rx_char_in == `LMS_CH_SOM) begin
                            mode_q <= lms_pkg::LMS_CTRL_RECV;
                            slash_seen_q <= 1'b0;
                        end else if (slash_seen_q) begin
                            slash_seen_q <= 1'b0;
                            if (rx_char_in == `LMS_CH_SPACE &&
                                (ctrl_q[`LMS_CTRL_MASTER_BIT] || has_status_in)) begin
                                mode_q <= lms_pkg::LMS_ADDR_SEL;
                                group_hit_q <= 1'b1;
                            end
                        end else if (rx_char_in == `LMS_CH_SLASH) begin
                            slash_seen_q <= 1'b1;
                        end else if (is_alpha(rx_char_in) && rx_char_in == indiv_addr) begin
                            mode_q <= lms_pkg::LMS_ADDR_SEL;
                            group_hit_q <= 1'b0;
                        end else if (is_alpha(rx_char_in) && rx_char_in == group_addr &&
                                     (ctrl_q[`LMS_CTRL_MASTER_BIT] || has_status_in)) begin
                            mode_q <= lms_pkg::LMS_ADDR_SEL;
                            group_hit_q <= 1'b1;
                        end
                    end
                    lms_pkg::LMS_ADDR_SEL: begin
                        if (rx_char_in == `LMS_CH_EOT) mode_q <= lms_pkg::LMS_TEXT_NONSEL;
                        else if (rx_char_in == `LMS_CH_SOM) mode_q <= lms_pkg::LMS_RECV_TEXT;
                    end
                    lms_pkg::LMS_RECV_TEXT: begin
                        if (rx_char_in == `LMS_CH_EOT) mode_q <= lms_pkg::LMS_CTRL_RECV;
                    end
                    lms_pkg::LMS_XMIT_TEXT: begin
                    end
                    lms_pkg::LMS_POLL_ANS: begin
                    end
                    default: mode_q <= lms_pkg::LMS_TEXT_NONSEL;
                endcase
            end
        end
    end

    // Pending bid request, set wins over clear
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pend_q <= 1'b0;
        end else if (clk_en_in) begin
            if (ctrl_q[`LMS_CTRL_BID_BIT]) pend_q <= 1'b1;
            else if (mode_q == lms_pkg::LMS_XMIT_TEXT) pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            control_clock_gate_out <= 1'b0;
            dial_disconnect_out <= 1'b0;
            keyboard_strobe_block_out <= 1'b0;
            bell_out <= 1'b0;
            motor_on_out <= 1'b0;
            keyboard_unlock_out <= 1'b0;
            mode_trig_out <= 4'he;
        end else if (clk_en_in) begin
            control_clock_gate_out <= tc_sel && !blanking_in && !first_clock_phase_in &&
                                      timeout_q;
            dial_disconnect_out <= (timeout_q && !carrier_in) ||
                                   ctrl_q[`LMS_CTRL_DIAL_BIT];
            keyboard_strobe_block_out <= timeout_q;
            // bell pulse, motor, unlock after start-of-message sent
            bell_out <= som_wait_q && tx_done_in;
            if (som_wait_q && tx_done_in) begin
                motor_on_out <= 1'b1;
                keyboard_unlock_out <= 1'b1;
            end else if (mode_q != lms_pkg::LMS_XMIT_TEXT) begin
                keyboard_unlock_out <= 1'b0;
            end
            mode_trig_out <= trig_of(mode_q);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_cts_low_early: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        $rose(rts_in) && clk_en_in |=> !cts_out) else $error("cts rose too early");
    chk_gate_needs_to: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        control_clock_gate_out |-> $past(timeout_q)) else $error("gate without timeout");
    chk_block_follows: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        timeout_q && clk_en_in |=> keyboard_strobe_block_out) else $error("no block");
    chk_disc_nocar: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        timeout_q && !carrier_in && clk_en_in |=> dial_disconnect_out)
        else $error("no disconnect");
    chk_nonsel_eot: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        mode_q == lms_pkg::LMS_TEXT_NONSEL && rx_valid_in && clk_en_in &&
        rx_char_in != `LMS_CH_EOT |=> mode_q == lms_pkg::LMS_TEXT_NONSEL)
        else $error("nonselected left");
    chk_space_xmit: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        mode_q == lms_pkg::LMS_INTER_CTRL && rx_valid_in && clk_en_in && !timeout_q &&
        rx_char_in == `LMS_CH_SPACE |=> bid_out && tx_valid_out)
        else $error("space not handled");
    chk_nonspace_back: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        mode_q == lms_pkg::LMS_INTER_CTRL && rx_valid_in && clk_en_in && !timeout_q &&
        rx_char_in != `LMS_CH_SPACE |=> mode_q == lms_pkg::LMS_CTRL_RECV)
        else $error("no return");
    chk_som_recv: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        mode_q == lms_pkg::LMS_CTRL_RECV && rx_valid_in && clk_en_in &&
        rx_char_in == `LMS_CH_SOM |=> mode_q == lms_pkg::LMS_RECV_TEXT)
        else $error("no receive");

endmodule

/* File: sim/lms_host_model.sv */
// Host multiplexer model driving the character line
`timescale 1ns/1ps
module lms_host_model (
    input wire logic clk_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_char_in,
    output logic rx_valid_out,
    output logic [7:0] rx_char_out,
    output logic tx_done_out
);
    logic [7:0] last_tx = 8'h00;
    int tx_count = 0;
    logic [2:0] done_sr = 3'h0;
    initial begin
        rx_valid_out = 1'b0;
        rx_char_out = 8'h00;
    end
    // One character per call; idle data shows the inverse
    // end with EOT is sent by tests via this task
    task automatic send(input logic [7:0] c);
        @(posedge clk_in);
        rx_valid_out <= 1'b1;
        rx_char_out <= c;
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        rx_char_out <= ~c;
    endtask
    // Line sends each returned character in three cycles
    always @(posedge clk_in) begin
        done_sr <= {done_sr[1:0], tx_valid_in === 1'b1};
        if (tx_valid_in === 1'b1) begin
            last_tx <= tx_char_in;
            tx_count <= tx_count + 1;
        end
    end
    assign tx_done_out = done_sr[2];
endmodule

/* File: sim/line_mode_sequencer_tb.sv */
// Self-checking bench for the line mode sequencer
`timescale 1ns/1ps
`include "lms_defs.svh"
module line_mode_sequencer_tb;
    logic clk, rst_b, hsel, hwrite, rx_valid, tx_done, rts, dsr, carrier, tx_valid, bell, bid;
    logic cts, gate, disc, kblock, motor, unlock, hready, hresp;
    logic clk_en, phase1, op_eot, has_stat;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] rx_char, tx_char;
    logic [3:0] trig;
    lms_pkg::lms_idle_s idle;
    int num_errors = 0;
    int n_tests = 0;
    int bells = 0;
    int gates = 0;
    int blocks = 0;
    int discs = 0;
    lms_sequencer #(.IDLE_CYCLES(50), .CTS_CYCLES(20)) u_dut (.core_clk_in(clk),
        .rst_b_in(rst_b), .clk_en_in(clk_en), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .rx_valid_in(rx_valid), .rx_char_in(rx_char), .tx_done_in(tx_done), .idle_in(idle),
        .rts_in(rts), .dsr_in(dsr), .carrier_in(carrier), .blanking_in(1'b0),
        .first_clock_phase_in(phase1), .operator_eot_in(op_eot), .has_status_in(has_stat),
        .tx_valid_out(tx_valid), .tx_char_out(tx_char), .cts_out(cts),
        .control_clock_gate_out(gate), .dial_disconnect_out(disc),
        .keyboard_strobe_block_out(kblock), .bell_out(bell), .motor_on_out(motor),
        .keyboard_unlock_out(unlock), .mode_trig_out(trig), .bid_out(bid));
    lms_host_model u_host (.clk_in(clk), .tx_valid_in(tx_valid), .tx_char_in(tx_char),
        .rx_valid_out(rx_valid), .rx_char_out(rx_char), .tx_done_out(tx_done));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Counters of cycles spent high by the bell, gate, block and disconnect outputs
    always @(posedge clk) begin
        if (bell === 1'b1) bells <= bells + 1;
        if (gate === 1'b1) gates <= gates + 1;
        if (kblock === 1'b1) blocks <= blocks + 1;
        if (disc === 1'b1) discs <= discs + 1;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chars(input string s);
        for (int i = 0; i < s.len(); i++) u_host.send(8'(s[i]));
        repeat (3) @(posedge clk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(40 * 5000);
        num_errors++;
        complete_run();
    end
    initial begin
        rst_b = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; rts = 1'b0; dsr = 1'b0; carrier = 1'b1; idle = '0;
        clk_en = 1'b1;
        phase1 = 1'b0;
        op_eot = 1'b0;
        has_stat = 1'b1;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("trig", trig, 32'h0000000e);
        bus(1'b0, `LMS_ADDR_STAT, 32'h0);
        check("stat", rd, 32'h00000001);
        chars("\002/");
        check("trig", trig, 32'h0000000e);
        chars("\004");
        check("trig", trig, 32'h0000000c);
        $display("power-up test done");
        bus(1'b1, `LMS_ADDR_CTRL, 32'h00000001);
        chars("/");
        check("trig", trig, 32'h0000000d);
        chars("x");
        check("trig", trig, 32'h0000000c);
        chars("/ ");
        check("tx", u_host.last_tx, 32'(`LMS_CH_SOM));
        check("bid", bid, 32'h1);
        repeat (5) @(posedge clk);
        check("bell", bells, 32'h1);
        check("motor", {motor, unlock}, 32'h3);
        idle <= '1;
        repeat (60) @(posedge clk);
        check("trig b", trig[2], 32'h1);
        idle <= '0;
        $display("turn-around test done");
        bus(1'b1, `LMS_ADDR_JUMP, 32'h00004241);
        chars("\004,Z");
        check("trig", trig, 32'h00000004);
        has_stat <= 1'b0;
        chars("B");
        check("trig", trig, 32'h00000004);
        has_stat <= 1'b1;
        chars("A");
        check("trig", trig, 32'h00000005);
        chars("\004\004A ");
        check("tx", u_host.last_tx, 32'(`LMS_CH_NAK));
        chars("B ");
        check("trig", trig, 32'h0000000c);
        bus(1'b1, `LMS_ADDR_CTRL, 32'h00000009);
        chars("A ");
        check("trig", trig, 32'h0000000a);
        check("tx count", u_host.tx_count, 32'h3);
        op_eot <= 1'b1;
        @(posedge clk);
        op_eot <= 1'b0;
        repeat (2) @(posedge clk);
        check("eot", trig, 32'h0000000c);
        clk_en <= 1'b0;
        chars("/");
        check("frozen", trig, 32'h0000000c);
        clk_en <= 1'b1;
        bus(1'b0, 32'h00000010, 32'h0);
        check("unmapped", rd, 32'h0);
        $display("address test done");
        rts <= 1'b1;
        repeat (10) @(posedge clk);
        check("cts early", cts, 32'h0);
        repeat (15) @(posedge clk);
        check("cts late", cts, 32'h1);
        dsr <= 1'b1; carrier <= 1'b0;
        phase1 <= 1'b1;
        repeat (40) @(posedge clk);
        carrier <= 1'b1;
        @(posedge clk);
        carrier <= 1'b0;
        repeat (40) @(posedge clk);
        check("early disc", disc, 32'h0);
        repeat (20) @(posedge clk);
        check("disc", discs, 32'h1);
        check("gate", gates, 32'h2);
        check("block", blocks, 32'h3);
        $display("modem test done");
        complete_run();
    end
endmodule
